// ### rtl/ltm_defines.vh
// constants for the lin transceiver mode controller
`ifndef LTM_DEFINES_VH
`define LTM_DEFINES_VH

`define LTM_CLK_MHZ     25
`define LTM_TMO_US      10000
`define LTM_TMO_W       24

`define LTM_OFS_CTRL    8'h00
`define LTM_OFS_IRQS    8'h04
`define LTM_OFS_IRQCLR  8'h08
`define LTM_OFS_IRQEN   8'h0c
`define LTM_OFS_STAT    8'h10

`define LTM_B_EN        0
`define LTM_B_TXD       9
`define LTM_B_RXD       10
`define LTM_B_HV        21
`define LTM_B_ONE22     22
`define LTM_B_ONE19     19
`define LTM_B_ONE20     20

`define LTM_B_TMO_STS   11
`define LTM_B_OVERTEMP_STATUS_FLAG    9
`define LTM_B_ERR_STS   8
`define LTM_B_TMO_IS    6
`define LTM_B_OVERCURRENT_IRQ_FLAG     5
`define LTM_B_OVERTEMP_IRQ_FLAG     4
`define LTM_B_ERR_IS    3
`define LTM_B_OVERCURRENT_STATUS_FLAG    0

`define LTM_F_MODE      2:1
`define LTM_F_MFB       6:4
`define LTM_F_SM        12:11
`define LTM_F_SFB       15:13
`define LTM_F_IEN       6:3
`define LTM_F_STATE     2:1
`define LTM_F_LOW       2:0
`define LTM_F_CLR       11:0

`define LTM_IE_ERR      0
`define LTM_IE_OT       1
`define LTM_IE_OC       2
`define LTM_IE_TMO      3

`define LTM_LOW_ONES    3'h7

`define LTM_MODE_SLEEP  2'h0
`define LTM_MODE_ROM    2'h1
`define LTM_MODE_NU     2'h2
`define LTM_MODE_NORM   2'h3

`define LTM_SM_NORMAL   2'h0
`define LTM_SM_FAST     2'h1
`define LTM_SM_LOW      2'h2
`define LTM_SM_FLASH    2'h3

`define LTM_MFB_OFF     3'h0
`define LTM_MFB_SLEEP   3'h1
`define LTM_MFB_ERR     3'h2
`define LTM_MFB_ROM     3'h5
`define LTM_MFB_NORM    3'h7

`define LTM_SFB_OFF     3'h0
`define LTM_SFB_LOW     3'h1
`define LTM_SFB_NORMAL  3'h2
`define LTM_SFB_FAST    3'h3
`define LTM_SFB_FLASH   3'h4

`define LTM_RST_MODE    2'h3
`define LTM_RST_SM      2'h0
`define LTM_RST_EN      1'b1
`define LTM_RST_TXD     1'b1

`endif

// ### rtl/ltm_mode_ctrl.v
// lin transceiver mode control state machine with apb registers
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "ltm_defines.vh"

module ltm_mode_ctrl #(
	parameter TMO_US = `LTM_TMO_US
) (
	input  wire        clk,
	input  wire        rst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        txdInt,
	output reg         rxdOut,
	input  wire        busIn,
	output wire        busOut,
	output reg         busOe,
	input  wire        ocDet,
	input  wire        otDet,
	input  wire        vsUv,
	input  wire        fbFault,
	input  wire        wakeDisable,
	output reg         wakeRxEn,
	output reg         wakeReq,
	output reg         txOn,
	output reg         rxOn,
	output reg  [1:0]  slopeSel,
	output reg         intNodeTen
);

	localparam [1:0] ST_SLEEP = 2'h0;
	localparam [1:0] ST_ROM   = 2'h1;
	localparam [1:0] ST_NORM  = 2'h2;
	localparam [1:0] ST_HV    = 2'h3;

	localparam integer TMO_CYC = TMO_US * `LTM_CLK_MHZ;
	localparam [`LTM_TMO_W-1:0] TMO_MAX = TMO_CYC[`LTM_TMO_W-1:0];

	function [2:0] slopeCode;
		input [1:0] sm;
		begin
			case (sm)
				`LTM_SM_LOW:   slopeCode = `LTM_SFB_LOW;
				`LTM_SM_FAST:  slopeCode = `LTM_SFB_FAST;
				`LTM_SM_FLASH: slopeCode = `LTM_SFB_FLASH;
				default:       slopeCode = `LTM_SFB_NORMAL;
			endcase
		end
	endfunction

	function modeOk;
		input [2:0] c;
		begin
			modeOk = (c == `LTM_MFB_SLEEP) || (c == `LTM_MFB_ROM) ||
				(c == `LTM_MFB_NORM);
		end
	endfunction

	function slopeOk;
		input [2:0] c;
		begin
			slopeOk = (c != `LTM_SFB_OFF) && (c <= `LTM_SFB_FLASH);
		end
	endfunction

	reg  [1:0] state_ff;
	reg  [1:0] nxt_state;
	reg        en_ff;
	reg  [1:0] mode_ff;
	reg  [1:0] sm_ff;
	reg        hv_ff;
	reg        hvArm_ff;
	reg        txd_ff;
	reg        rxd_ff;
	reg        tmoSts_ff;
	reg        otSts_ff;
	reg        errSts_ff;
	reg        tmoIs_ff;
	reg        ocIs_ff;
	reg        otIs_ff;
	reg        errIs_ff;
	reg        ocSts_ff;
	reg  [3:0] irqEn_ff;
	reg  [`LTM_TMO_W-1:0] tmoCnt_ff;

	wire wrAcc = psel & penable & pwrite;
	wire wrCtrl = wrAcc && (paddr == `LTM_OFS_CTRL);
	wire wrClr = wrAcc && (paddr == `LTM_OFS_IRQCLR);
	wire wrEn = wrAcc && (paddr == `LTM_OFS_IRQEN);
	wire wrStat = wrAcc && (paddr == `LTM_OFS_STAT);
	wire mapped = (paddr == `LTM_OFS_CTRL) || (paddr == `LTM_OFS_IRQS) ||
		(paddr == `LTM_OFS_IRQCLR) || (paddr == `LTM_OFS_IRQEN) ||
		(paddr == `LTM_OFS_STAT);

	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	// open-drain line: only ever pulled low
	assign busOut = 1'b0;

	reg [2:0] modeFb;
	always @* begin
		if (!en_ff) begin
			modeFb = `LTM_MFB_OFF;
		end else if (fbFault) begin
			modeFb = `LTM_MFB_ERR;
		end else begin
			case (state_ff)
				ST_SLEEP: modeFb = `LTM_MFB_SLEEP;
				ST_ROM:   modeFb = `LTM_MFB_ROM;
				default:  modeFb = `LTM_MFB_NORM;
			endcase
		end
	end

	wire [2:0] slopeFb = en_ff ? slopeCode(sm_ff) : `LTM_SFB_OFF;
	wire fbOk = modeOk(modeFb) && slopeOk(slopeFb);
	wire tmoHit = (tmoCnt_ff == TMO_MAX);

	// faults that keep the transmitter from normal mode
	wire faultAny = ocIs_ff | ocSts_ff | vsUv | otSts_ff | tmoSts_ff;
	wire otOc = otSts_ff | ocSts_ff;

	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_SLEEP: begin
				if (hv_ff && hvArm_ff && mode_ff == `LTM_MODE_NORM &&
					fbOk && !otOc) begin
					nxt_state = ST_HV;
				end else if (mode_ff == `LTM_MODE_NORM && fbOk && !hv_ff &&
					!faultAny) begin
					nxt_state = ST_NORM;
				end else if (mode_ff == `LTM_MODE_ROM && fbOk && !hv_ff) begin
					nxt_state = ST_ROM;
				end
			end
			ST_ROM: begin
				if (mode_ff == `LTM_MODE_SLEEP) begin
					nxt_state = ST_SLEEP;
				end else if (mode_ff == `LTM_MODE_NORM && fbOk && !faultAny) begin
					nxt_state = ST_NORM;
				end
			end
			ST_NORM: begin
				if (mode_ff == `LTM_MODE_SLEEP) begin
					nxt_state = ST_SLEEP;
				end else if (mode_ff == `LTM_MODE_ROM || !fbOk || faultAny) begin
					nxt_state = ST_ROM;
				end
			end
			ST_HV: begin
				if (mode_ff == `LTM_MODE_SLEEP || !fbOk || otOc) begin
					nxt_state = ST_SLEEP;
				end
			end
			default: nxt_state = ST_SLEEP;
		endcase
	end
	// the unused mode code matches no branch above, so it holds the state

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff <= ST_SLEEP;
		end else if (!en_ff) begin
			state_ff <= ST_SLEEP;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// control register; a cleared enable returns every other field to reset
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			en_ff <= `LTM_RST_EN;
			mode_ff <= `LTM_RST_MODE;
			sm_ff <= `LTM_RST_SM;
			hv_ff <= 1'b0;
			hvArm_ff <= 1'b0;
			txd_ff <= `LTM_RST_TXD;
		end else if (wrCtrl) begin
			en_ff <= pwdata[`LTM_B_EN];
			if (!pwdata[`LTM_B_EN]) begin
				mode_ff <= `LTM_RST_MODE;
				sm_ff <= `LTM_RST_SM;
				hv_ff <= 1'b0;
				hvArm_ff <= 1'b0;
				txd_ff <= `LTM_RST_TXD;
			end else begin
				mode_ff <= pwdata[`LTM_F_MODE];
				hv_ff <= pwdata[`LTM_B_HV];
				txd_ff <= pwdata[`LTM_B_TXD];
				// normal must be requested by a write after hv was already set
				hvArm_ff <= hv_ff && pwdata[`LTM_B_HV] &&
					(pwdata[`LTM_F_MODE] == `LTM_MODE_NORM);
				if (state_ff != ST_NORM) begin
					sm_ff <= pwdata[`LTM_F_SM];
				end
			end
		end else if (state_ff == ST_HV || !hv_ff) begin
			hvArm_ff <= 1'b0;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			irqEn_ff <= 4'h0;
		end else if (!en_ff) begin
			irqEn_ff <= 4'h0;
		end else if (wrEn) begin
			irqEn_ff <= pwdata[`LTM_F_IEN];
		end
	end

	// dominant timeout counter saturates, so the flag re-sets until txd goes recessive
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			tmoCnt_ff <= {`LTM_TMO_W{1'b0}};
		end else if (!en_ff || txdInt) begin
			tmoCnt_ff <= {`LTM_TMO_W{1'b0}};
		end else if (!tmoHit) begin
			tmoCnt_ff <= tmoCnt_ff + 1'b1;
		end
	end

	// sticky flags: a set in the clearing cycle wins
	wire [`LTM_F_CLR] clrBits = wrClr ? pwdata[`LTM_F_CLR] : 12'h000;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			tmoSts_ff <= 1'b0;
			tmoIs_ff <= 1'b0;
			otSts_ff <= 1'b0;
			otIs_ff <= 1'b0;
			ocIs_ff <= 1'b0;
			ocSts_ff <= 1'b0;
			errSts_ff <= 1'b0;
			errIs_ff <= 1'b0;
		end else if (!en_ff) begin
			tmoSts_ff <= 1'b0;
			tmoIs_ff <= 1'b0;
			otSts_ff <= 1'b0;
			otIs_ff <= 1'b0;
			ocIs_ff <= 1'b0;
			ocSts_ff <= 1'b0;
			errSts_ff <= 1'b0;
			errIs_ff <= 1'b0;
		end else begin
			tmoSts_ff <= tmoHit | (tmoSts_ff & ~clrBits[`LTM_B_TMO_STS]);
			tmoIs_ff <= tmoHit | (tmoIs_ff & ~clrBits[`LTM_B_TMO_IS]);
			otSts_ff <= otDet | (otSts_ff & ~clrBits[`LTM_B_OVERTEMP_STATUS_FLAG]);
			otIs_ff <= otDet | (otIs_ff & ~clrBits[`LTM_B_OVERTEMP_IRQ_FLAG]);
			ocIs_ff <= ocDet | (ocIs_ff & ~clrBits[`LTM_B_OVERCURRENT_IRQ_FLAG]);
			ocSts_ff <= ocDet |
				(ocSts_ff & ~(wrStat & pwdata[`LTM_B_OVERCURRENT_STATUS_FLAG]));
			errSts_ff <= ~fbOk | (errSts_ff & ~clrBits[`LTM_B_ERR_STS]);
			errIs_ff <= ~fbOk | (errIs_ff & ~clrBits[`LTM_B_ERR_IS]);
		end
	end

	// pin and path controls, registered so the analog side sees clean levels
	wire nTxOn = (state_ff == ST_NORM) && !tmoSts_ff && !otSts_ff &&
		!ocDet;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			txOn <= 1'b0;
			rxOn <= 1'b0;
			busOe <= 1'b0;
			rxdOut <= 1'b1;
			rxd_ff <= 1'b1;
			wakeRxEn <= 1'b0;
			wakeReq <= 1'b0;
			slopeSel <= `LTM_RST_SM;
			intNodeTen <= 1'b0;
		end else begin
			txOn <= nTxOn | (state_ff == ST_HV);
			rxOn <= (state_ff == ST_ROM) || (state_ff == ST_NORM) ||
				(state_ff == ST_HV);
			if (state_ff == ST_HV) begin
				busOe <= ~txd_ff;
			end else begin
				busOe <= nTxOn & ~txdInt;
			end
			rxdOut <= ((state_ff == ST_ROM) || (state_ff == ST_NORM)) ?
				busIn : 1'b1;
			rxd_ff <= busIn;
			wakeRxEn <= (state_ff == ST_SLEEP) && en_ff && !wakeDisable;
			wakeReq <= (state_ff == ST_SLEEP) && en_ff && !wakeDisable &&
				!busIn;
			slopeSel <= sm_ff;
			intNodeTen <= (ocIs_ff & irqEn_ff[`LTM_IE_OC]) |
				(otIs_ff & irqEn_ff[`LTM_IE_OT]) |
				(tmoIs_ff & irqEn_ff[`LTM_IE_TMO]) |
				(errIs_ff & irqEn_ff[`LTM_IE_ERR]);
		end
	end

	// read word; reserved bits follow their fixed values
	reg [31:0] nxt_prdata;
	always @* begin
		nxt_prdata = 32'h0000_0000;
		if (psel && !pwrite) begin
			case (paddr)
				`LTM_OFS_CTRL: begin
					nxt_prdata[`LTM_B_EN] = en_ff;
					nxt_prdata[`LTM_F_MODE] = mode_ff;
					nxt_prdata[`LTM_F_MFB] = modeFb;
					nxt_prdata[`LTM_B_TXD] = txd_ff;
					nxt_prdata[`LTM_B_RXD] = rxd_ff;
					nxt_prdata[`LTM_F_SM] = sm_ff;
					nxt_prdata[`LTM_F_SFB] = slopeFb;
					nxt_prdata[`LTM_B_ONE19] = 1'b1;
					nxt_prdata[`LTM_B_ONE20] = 1'b1;
					nxt_prdata[`LTM_B_HV] = hv_ff;
					nxt_prdata[`LTM_B_ONE22] = 1'b1;
				end
				`LTM_OFS_IRQS: begin
					nxt_prdata[`LTM_F_LOW] = `LTM_LOW_ONES;
					nxt_prdata[`LTM_B_ERR_IS] = errIs_ff;
					nxt_prdata[`LTM_B_OVERTEMP_IRQ_FLAG] = otIs_ff;
					nxt_prdata[`LTM_B_OVERCURRENT_IRQ_FLAG] = ocIs_ff;
					nxt_prdata[`LTM_B_TMO_IS] = tmoIs_ff;
					nxt_prdata[`LTM_B_ERR_STS] = errSts_ff;
					nxt_prdata[`LTM_B_OVERTEMP_STATUS_FLAG] = otSts_ff;
					nxt_prdata[`LTM_B_TMO_STS] = tmoSts_ff;
				end
				`LTM_OFS_IRQCLR: nxt_prdata[`LTM_F_LOW] = `LTM_LOW_ONES;
				`LTM_OFS_IRQEN: begin
					nxt_prdata[`LTM_F_LOW] = `LTM_LOW_ONES;
					nxt_prdata[`LTM_F_IEN] = irqEn_ff;
				end
				`LTM_OFS_STAT: begin
					nxt_prdata[`LTM_B_OVERCURRENT_STATUS_FLAG] = ocSts_ff;
					nxt_prdata[`LTM_F_STATE] = state_ff;
				end
				default: nxt_prdata = 32'h0000_0000;
			endcase
		end
	end

	// taken in the setup cycle so the word stands from a flop through the access cycle
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata <= nxt_prdata;
		end
	end

endmodule
`default_nettype wire

// ### verif/ltm_mode_ctrl_monitor.sv
// concurrent checks on the ports of the lin transceiver mode controller
`timescale 1ns/100ps
`default_nettype none
module ltm_mode_monitor #(
	parameter TMO_US = 10000
) (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pslverr,
	input wire logic        txdInt,
	input wire logic        rxdOut,
	input wire logic        busIn,
	input wire logic        busOe,
	input wire logic        ocDet,
	input wire logic        otDet,
	input wire logic        wakeDisable,
	input wire logic        wakeRxEn,
	input wire logic        wakeReq,
	input wire logic        txOn,
	input wire logic        rxOn,
	input wire logic [1:0]  slopeSel
);
	localparam int TMO_CYC = TMO_US * 25;
	logic [31:0] domCnt_ff;
	logic [31:0] nxt_domCnt;

	// saturates just past the limit so a stuck line cannot wrap the count
	assign nxt_domCnt = txdInt ? 32'h0 : (domCnt_ff > TMO_CYC + 4) ? domCnt_ff : domCnt_ff + 32'h1;

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			domCnt_ff <= 32'h0;
		else
			domCnt_ff <= nxt_domCnt;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_otHeld; otDet [*3]; endsequence
	sequence s_ocHeld; ocDet [*3]; endsequence
	sequence s_disWrite; psel && penable && pwrite && paddr == 8'h00 && !pwdata[0]; endsequence
	sequence s_allOff; !txOn && !rxOn && !busOe && !wakeRxEn && slopeSel == 2'h0; endsequence

	property p_otQuiet; s_otHeld |-> ##1 (!busOe && !txOn); endproperty
	a_otQuiet: assert property (p_otQuiet) else $error("bus driven under overtemperature");
	property p_ocQuiet; s_ocHeld |-> ##1 (!busOe && !txOn); endproperty
	a_ocQuiet: assert property (p_ocQuiet) else $error("bus driven under overcurrent");
	property p_tmoQuiet; domCnt_ff > TMO_CYC + 3 |-> !busOe; endproperty
	a_tmoQuiet: assert property (p_tmoQuiet) else $error("bus driven after dominant timeout");
	property p_sleepPaths; wakeRxEn |-> !txOn && !rxOn && !$past(wakeDisable); endproperty
	a_sleepPaths: assert property (p_sleepPaths) else $error("paths wrong in sleep");
	property p_wakeBus; wakeReq |-> !$past(busIn); endproperty
	a_wakeBus: assert property (p_wakeBus) else $error("wake without dominant bus");
	property p_rxQuiet; !rxOn |-> rxdOut; endproperty
	a_rxQuiet: assert property (p_rxQuiet) else $error("receive data with receiver off");
	property p_errPhase; pslverr |-> psel && penable; endproperty
	a_errPhase: assert property (p_errPhase) else $error("slave error outside access phase");
	property p_unmapped; psel && penable && paddr > 8'h10 |-> pslverr; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	property p_disable; s_disWrite |-> ##3 s_allOff; endproperty
	a_disable: assert property (p_disable) else $error("module not reset by enable clear");
endmodule

bind ltm_mode_ctrl ltm_mode_monitor #(.TMO_US(TMO_US)) uMon (
	.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pslverr(pslverr), .txdInt(txdInt), .rxdOut(rxdOut), .busIn(busIn),
	.busOe(busOe), .ocDet(ocDet), .otDet(otDet), .wakeDisable(wakeDisable),
	.wakeRxEn(wakeRxEn), .wakeReq(wakeReq), .txOn(txOn), .rxOn(rxOn), .slopeSel(slopeSel)
);
`default_nettype wire

// ### verif/ltm_bus_peer.sv
// single-wire bus with pull-up and one other node that can pull it dominant
`timescale 1ns/100ps
`default_nettype none
module ltm_bus_peer (
	input  wire logic busOe,
	input  wire logic peerDom,
	output wire logic busIn
);
	// wired-and: any node pulling low wins, the pull-up leaves it recessive otherwise
	assign busIn = !(busOe || peerDom);
endmodule
`default_nettype wire

// ### verif/ltm_tb.sv
// self-checking testbench for the lin transceiver mode controller
`timescale 1ns/100ps
`default_nettype none
`include "ltm_defines.vh"
module tb;
	logic        clk, rst, psel, penable, pwrite, txdInt, ocDet, otDet;
	logic        vsUv, fbFault, wakeDisable, peerDom, er;
	logic [7:0]  paddr;
	logic [31:0] pwdata, rd, prdata;
	logic        pready, pslverr, rxdOut, busIn, busOut, busOe, wakeRxEn, wakeReq;
	logic        txOn, rxOn, intNodeTen;
	logic [1:0]  slopeSel;
	logic [2:0]  sfb [4] = '{`LTM_SFB_NORMAL, `LTM_SFB_FAST, `LTM_SFB_LOW, `LTM_SFB_FLASH};
	int          errCount, totalChecks, i;

	// small timeout value keeps the dominant timeout at 100 cycles
	ltm_mode_ctrl #(.TMO_US(4)) uut (
		.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .txdInt(txdInt),
		.rxdOut(rxdOut), .busIn(busIn), .busOut(busOut), .busOe(busOe), .ocDet(ocDet),
		.otDet(otDet), .vsUv(vsUv), .fbFault(fbFault), .wakeDisable(wakeDisable),
		.wakeRxEn(wakeRxEn), .wakeReq(wakeReq), .txOn(txOn), .rxOn(rxOn), .slopeSel(slopeSel),
		.intNodeTen(intNodeTen)
	);
	ltm_bus_peer peer (.busOe(busOe), .peerDom(peerDom), .busIn(busIn));

	always #20 clk = ~clk;

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		totalChecks++;
		if (g !== e) begin
			errCount++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task chkb(input string n, input logic e, input logic g);
		chk(n, {31'h0, e}, {31'h0, g});
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1) @(posedge clk);
		r = prdata;
		er = pslverr;
		psel <= 1'h0; penable <= 1'h0;
		@(posedge clk);
	endtask

	task md(input logic [1:0] m, input logic [1:0] s, input logic h, input logic t);
		apb(1'h1, `LTM_OFS_CTRL, {10'h0, h, 8'h0, s, 1'h0, t, 6'h0, m, 1'h1}, rd);
		repeat (3) @(posedge clk);
	endtask

	task st(input logic [1:0] s);
		apb(1'h0, `LTM_OFS_STAT, 32'h0, rd);
		chk("state", {30'h0, s}, {30'h0, rd[2:1]});
	endtask

	task tReset;
		apb(1'h0, `LTM_OFS_CTRL, 32'h0, rd);
		chk("ctrl", 32'h00584677, rd);
		st(2'h2);
		apb(1'h0, 8'h20, 32'h0, rd);
		chkb("slverr", 1'h1, er);
		chkb("busOut", 1'h0, busOut);
		apb(1'h0, `LTM_OFS_IRQS, 32'h0, rd);
		chk("irqs", 32'h7, rd);
		$display("reset test done");
	endtask

	task tModes;
		md(2'h0, 2'h0, 1'h0, 1'h1);
		st(2'h0);
		chk("paths", 32'h4, {29'h0, wakeRxEn, txOn, rxOn});
		peerDom <= 1'h1;
		repeat (2) @(posedge clk);
		chkb("wakeReq", 1'h1, wakeReq);
		wakeDisable <= 1'h1;
		peerDom <= 1'h0;
		repeat (2) @(posedge clk);
		chkb("wakeRxEn", 1'h0, wakeRxEn);
		wakeDisable <= 1'h0;
		md(2'h2, 2'h0, 1'h0, 1'h1);
		st(2'h0);
		md(2'h1, 2'h0, 1'h0, 1'h1);
		st(2'h1);
		chk("paths", 32'h1, {29'h0, wakeRxEn, txOn, rxOn});
		for (i = 0; i < 4; i++) begin
			md(2'h1, i[1:0], 1'h0, 1'h1);
			apb(1'h0, `LTM_OFS_CTRL, 32'h0, rd);
			chk("slopeFb", {29'h0, sfb[i]}, {29'h0, rd[15:13]});
			chk("slopeSel", i, {30'h0, slopeSel});
		end
		md(2'h3, 2'h3, 1'h0, 1'h1);
		st(2'h2);
		md(2'h3, 2'h0, 1'h0, 1'h1);
		chk("slopeSel", 32'h3, {30'h0, slopeSel});
		md(2'h1, 2'h0, 1'h0, 1'h1);
		st(2'h1);
		md(2'h0, 2'h0, 1'h0, 1'h1);
		st(2'h0);
		md(2'h3, 2'h0, 1'h0, 1'h1);
		$display("mode test done");
	endtask

	task tFault;
		apb(1'h1, `LTM_OFS_IRQEN, 32'h10, rd);
		apb(1'h0, `LTM_OFS_IRQEN, 32'h0, rd);
		chk("irqen", 32'h17, rd);
		vsUv <= 1'h1;
		repeat (3) @(posedge clk);
		st(2'h1);
		vsUv <= 1'h0;
		repeat (3) @(posedge clk);
		st(2'h2);
		otDet <= 1'h1;
		repeat (4) @(posedge clk);
		st(2'h1);
		chkb("irq", 1'h1, intNodeTen);
		otDet <= 1'h0;
		repeat (3) @(posedge clk);
		st(2'h1);
		apb(1'h0, `LTM_OFS_IRQS, 32'h0, rd);
		chk("irqs", 32'h217, rd);
		apb(1'h1, `LTM_OFS_IRQCLR, 32'h210, rd);
		repeat (3) @(posedge clk);
		st(2'h2);
		chkb("irq", 1'h0, intNodeTen);
		ocDet <= 1'h1;
		repeat (4) @(posedge clk);
		st(2'h1);
		chkb("irq", 1'h0, intNodeTen);
		apb(1'h1, `LTM_OFS_IRQCLR, 32'h20, rd);
		apb(1'h0, `LTM_OFS_IRQS, 32'h0, rd);
		chkb("ocIrq", 1'h1, rd[5]);
		ocDet <= 1'h0;
		apb(1'h1, `LTM_OFS_IRQEN, 32'h20, rd);
		// the interrupt output is one flop behind the enable register
		@(posedge clk);
		chkb("irq", 1'h1, intNodeTen);
		apb(1'h1, `LTM_OFS_IRQCLR, 32'h20, rd);
		apb(1'h1, `LTM_OFS_STAT, 32'h1, rd);
		repeat (3) @(posedge clk);
		st(2'h2);
		fbFault <= 1'h1;
		repeat (3) @(posedge clk);
		st(2'h1);
		apb(1'h0, `LTM_OFS_CTRL, 32'h0, rd);
		chk("modeFb", {29'h0, `LTM_MFB_ERR}, {29'h0, rd[6:4]});
		md(2'h0, 2'h0, 1'h0, 1'h1);
		st(2'h0);
		fbFault <= 1'h0;
		md(2'h3, 2'h0, 1'h0, 1'h1);
		st(2'h2);
		$display("fault test done");
	endtask

	task tTmo;
		txdInt <= 1'h0;
		repeat (3) @(posedge clk);
		chkb("rxdOut", 1'h0, rxdOut);
		repeat (110) @(posedge clk);
		st(2'h1);
		chkb("busOe", 1'h0, busOe);
		apb(1'h1, `LTM_OFS_IRQCLR, 32'h840, rd);
		apb(1'h0, `LTM_OFS_IRQS, 32'h0, rd);
		chkb("tmoSts", 1'h1, rd[11]);
		txdInt <= 1'h1;
		repeat (2) @(posedge clk);
		st(2'h1);
		apb(1'h1, `LTM_OFS_IRQCLR, 32'h840, rd);
		repeat (3) @(posedge clk);
		st(2'h2);
		$display("timeout test done");
	endtask

	task tHv;
		md(2'h0, 2'h0, 1'h1, 1'h1);
		md(2'h3, 2'h0, 1'h1, 1'h0);
		st(2'h3);
		chkb("busOe", 1'h1, busOe);
		apb(1'h0, `LTM_OFS_CTRL, 32'h0, rd);
		chkb("rxdBit", 1'h0, rd[10]);
		md(2'h3, 2'h0, 1'h1, 1'h1);
		chkb("busOe", 1'h0, busOe);
		md(2'h0, 2'h0, 1'h1, 1'h1);
		st(2'h0);
		md(2'h0, 2'h0, 1'h0, 1'h1);
		md(2'h3, 2'h0, 1'h0, 1'h1);
		st(2'h2);
		$display("hv test done");
	endtask

	task tDisable;
		md(2'h1, 2'h2, 1'h0, 1'h1);
		md(2'h1, 2'h2, 1'h0, 1'h1);
		chk("slopeSel", 32'h2, {30'h0, slopeSel});
		apb(1'h1, `LTM_OFS_CTRL, 32'h0, rd);
		repeat (3) @(posedge clk);
		apb(1'h0, `LTM_OFS_CTRL, 32'h0, rd);
		chk("fb", 32'h0, {26'h0, rd[15:13], rd[6:4]});
		chk("slopeSel", 32'h0, {30'h0, slopeSel});
		st(2'h0);
		md(2'h3, 2'h0, 1'h0, 1'h1);
		st(2'h2);
		$display("disable test done");
	endtask

	task conclude;
		$display("checks %0d mismatches %0d", totalChecks, errCount);
		if (errCount == 0 && totalChecks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		clk = 1'h0; rst = 1'h1; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
		paddr = 8'h0; pwdata = 32'h0; txdInt = 1'h1; ocDet = 1'h0; otDet = 1'h0;
		vsUv = 1'h0; fbFault = 1'h0; wakeDisable = 1'h0; peerDom = 1'h0;
		errCount = 0; totalChecks = 0;
		repeat (12) @(posedge clk);
		rst <= 1'h0;
		repeat (2) @(posedge clk);
		tReset;
		tModes;
		tFault;
		tTmo;
		tHv;
		tDisable;
		conclude;
	end

	// the whole sequence needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		errCount++;
		conclude;
	end
endmodule
`default_nettype wire
